// *** hdl/sysctl_pkg.sv ***
// Shared constants and carriers for the system control register bank.
// Assumes one 50 MHz core clock and a synchronous, active-high reset.
`default_nettype none

package sysctl_pkg;

    // ------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_NMI_STATUS   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_NMI_ENABLE   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_REVISION     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GPO          = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_WARM_REQ     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_WARM_DONE    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_POWER_CTRL   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_POWER_STATUS = 8'h1C;

    // ------------------------------------------------------------
    // Field widths, positions and masks
    // ------------------------------------------------------------
    localparam int NMI_W       = 6;
    localparam int NMI_EXT_BIT = 4;
    localparam int GPO_W       = 8;
    localparam int WARM_W      = 5;
    localparam int PWR_W       = 4;
    localparam int PWR_IDLE_LSB = 0;
    localparam int PWR_WKUP_LSB = 8;
    localparam int PWR_STOP_LSB = 16;
    localparam int REV_MINOR_LSB = 0;
    localparam int REV_MAJOR_LSB = 8;

    localparam logic [DATA_W-1:0] NMI_EN_MASK  = 32'h0000_003F;
    localparam logic [DATA_W-1:0] GPO_MASK     = 32'h0000_00FF;
    localparam logic [DATA_W-1:0] PWR_CTL_MASK = 32'h000F_000F;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
    localparam logic [NMI_W-1:0]  RST_NMI    = 6'h00;
    localparam logic [WARM_W-1:0] RST_WARM   = 5'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   byteEn;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic illegalRegAccess;
        logic memAddressError;
        logic ibusTimeout;
        logic ibusError;
        logic cpuBusError;
    } nmi_events_t;

endpackage

`default_nettype wire

// *** hdl/nmi_cause_tracker.sv ***
// Sticky NMI cause flags, read-clear, NMI output gated by per-cause enables.
// Assumes event pulses come from core_clk logic; the NMI pin is asynchronous.
`default_nettype none

module nmi_cause_tracker
    import sysctl_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire nmi_events_t      events,
    input  wire logic             external_nmi_pin_n,
    input  wire logic [NMI_W-1:0] enables,
    input  wire logic             clearStatus,
    output logic      [NMI_W-1:0] status,
    output logic                  nmiOut
);

    logic             pinMeta_reg;
    logic             pinSync_reg;
    logic             nmi_reg;
    logic [NMI_W-1:0] status_reg;
    wire  [NMI_W-1:0] causeSet;
    wire              nmi_next;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pinMeta_reg <= 1'b1;
            pinSync_reg <= 1'b1;
        end
        else
        begin
            pinMeta_reg <= external_nmi_pin_n;
            pinSync_reg <= pinMeta_reg;
        end
    end

    // RULE2 cause positions
    assign causeSet = {events.illegalRegAccess, ~pinSync_reg, events.memAddressError,
                       events.ibusTimeout, events.ibusError, events.cpuBusError};

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NMI_W; i++)
        begin : g_flag
            // RULE17 read clears, new event wins
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    status_reg[i] <= 1'b0;
                else if (causeSet[i])
                    status_reg[i] <= 1'b1;
                else if (clearStatus)
                    status_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // RULE1 enabled cause raises NMI
    assign nmi_next = |(status_reg & enables);

    always_ff @(posedge core_clk)
    begin
        if (reset)
            nmi_reg <= 1'b0;
        else
            nmi_reg <= nmi_next;
    end

    assign status = status_reg;
    assign nmiOut = nmi_reg;

endmodule

`default_nettype wire

// *** hdl/system_ctrl_nmi_reset_power_regs.sv ***
// System control register bank: NMI enables, revision, output port,
// warm-reset handshakes and power idle/clock-stop handshakes.
// Assumes the host register port and the peripheral handshakes run on core_clk.
//
// Overview of operation
// RULE1 - NMI asserts when any status bit and its matching enable bit are one.
// RULE2 - Enable bits: 5 illegal access, 4 pin, 3 memory, 2 timeout, 1 bus, 0 CPU.
// RULE3 - NMI enable clears on reset; bits 31:6 always read zero.
// RULE4 - Revision is read-only: major in 15:8, minor in 7:0, zero above.
// RULE5 - Output port low byte drives pins directly; resets zero; upper bits read zero.
// RULE6 - Writing one to a warm reset bit requests that unit's reset; zero ignored.
// RULE7 - Warm reset request register always reads as zero.
// RULE8 - Warm reset done bits: zero busy, one reset finished and unit ready.
// RULE9 - Power control bits 19:16 stop clocks of Eth2, ATM, Eth1, USB.
// RULE10 - Power control bits 3:0 request idle state; zero does nothing.
// RULE11 - Software sets idle request and sees idle before stopping a clock.
// RULE12 - Software drains its posted writes before touching power control.
// RULE13 - Power status bits 3:1 report idle for Eth2, ATM, Eth1.
// RULE14 - Power status bits 11:8 report pending wakeups for Eth2, ATM, Eth1, USB.
// RULE15 - Software clears a unit's clock stop when its wakeup bit reads one.
// RULE16 - Power status bit 0 reports USB idle, ready to suspend.
// RULE17 - NMI status clears when software reads the byte holding CPU bus error.
// RULE18 - Warm reset write gives a one-cycle pulse; done bit drops until completion.
`default_nettype none

module system_ctrl_nmi_reset_power_regs
    import sysctl_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [7:0] REV_MAJOR = 8'h0A,
    parameter logic [7:0] REV_MINOR = 8'h0B
)
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire reg_req_t          regReq,
    output logic      [DATA_W-1:0] regRdata,
    output logic                   regReadValid,
    input  wire nmi_events_t       nmiEvents,
    input  wire logic              external_nmi_pin_n,
    output logic                   nmiRequest,
    output logic      [GPO_W-1:0]  generalOutputPins,
    output logic      [WARM_W-1:0] warmResetPulse,
    input  wire logic [WARM_W-1:0] unitResetDone,
    output logic      [PWR_W-1:0]  clockGate,
    output logic      [PWR_W-1:0]  idleRequest,
    input  wire logic [PWR_W-1:0]  unitIdleAck,
    input  wire logic [PWR_W-1:0]  unitWakeup
);

    logic [DATA_W-1:0] nmiEnable_reg;
    logic [DATA_W-1:0] gpo_reg;
    logic [DATA_W-1:0] powerCtrl_reg;
    logic [WARM_W-1:0] warmPulse_reg;
    logic [WARM_W-1:0] warmDone_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic              rvalid_reg;

    logic [NMI_W-1:0]  nmiStatus;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire hitNmiStat  = regReq.addr == OFS_NMI_STATUS;
    wire hitNmiEn    = regReq.addr == OFS_NMI_ENABLE;
    wire hitRev      = regReq.addr == OFS_REVISION;
    wire hitGpo      = regReq.addr == OFS_GPO;
    wire hitWarmReq  = regReq.addr == OFS_WARM_REQ;
    wire hitWarmDone = regReq.addr == OFS_WARM_DONE;
    wire hitPwrCtl   = regReq.addr == OFS_POWER_CTRL;
    wire hitPwrStat  = regReq.addr == OFS_POWER_STATUS;

    wire wrNmiEn   = regReq.write && hitNmiEn;
    wire wrGpo     = regReq.write && hitGpo;
    wire wrWarmReq = regReq.write && hitWarmReq && regReq.byteEn[0];
    wire wrPwrCtl  = regReq.write && hitPwrCtl;

    // RULE17 byte 0 read clears NMI status
    wire clearNmi = regReq.read && hitNmiStat && regReq.byteEn[0];

    // ------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] mergeLanes(
        input logic [DATA_W-1:0] oldVal,
        input logic [DATA_W-1:0] newVal,
        input logic [BE_W-1:0]   be,
        input logic [DATA_W-1:0] mask
    );
        logic [DATA_W-1:0] res;
        res = oldVal;
        for (int b = 0; b < BE_W; b++)
        begin
            if (be[b])
                res[b*8 +: 8] = newVal[b*8 +: 8];
        end
        return res & mask;
    endfunction

    // RULE3 upper enable bits masked to zero
    wire [DATA_W-1:0] nmiEnable_next =
        mergeLanes(nmiEnable_reg, regReq.wdata, regReq.byteEn, NMI_EN_MASK);
    // RULE5 only the low byte is kept
    wire [DATA_W-1:0] gpo_next =
        mergeLanes(gpo_reg, regReq.wdata, regReq.byteEn, GPO_MASK);
    // RULE9 stop bits and RULE10 idle bits held
    wire [DATA_W-1:0] powerCtrl_next =
        mergeLanes(powerCtrl_reg, regReq.wdata, regReq.byteEn, PWR_CTL_MASK);

    // RULE6 ones request, zeros ignored
    wire [WARM_W-1:0] warmPulse_next =
        wrWarmReq ? regReq.wdata[WARM_W-1:0] : RST_WARM;

    // RULE18 request drops done; a new request beats a late completion
    wire [WARM_W-1:0] warmDone_next =
        (warmDone_reg | unitResetDone) & ~warmPulse_next;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // RULE4 fixed revision fields
    wire [DATA_W-1:0] revWord =
        {16'h0000, REV_MAJOR, REV_MINOR} & 32'h0000_FFFF;
    // RULE13 idle bits, RULE16 USB idle, RULE14 wakeup bits
    wire [DATA_W-1:0] pwrStatWord =
        ({{(DATA_W-PWR_W){1'b0}}, unitIdleAck} << PWR_IDLE_LSB) |
        ({{(DATA_W-PWR_W){1'b0}}, unitWakeup}  << PWR_WKUP_LSB);
    // RULE8 done bits in request positions
    wire [DATA_W-1:0] warmDoneWord = {{(DATA_W-WARM_W){1'b0}}, warmDone_reg};
    wire [DATA_W-1:0] nmiStatWord  = {{(DATA_W-NMI_W){1'b0}}, nmiStatus};

    // RULE7 request register reads zero; unmapped reads zero too
    wire [DATA_W-1:0] readWord =
        hitNmiStat  ? nmiStatWord   :
        hitNmiEn    ? nmiEnable_reg :
        hitRev      ? revWord       :
        hitGpo      ? gpo_reg       :
        hitWarmDone ? warmDoneWord  :
        hitPwrCtl   ? powerCtrl_reg :
        hitPwrStat  ? pwrStatWord   :
                      RST_WORD;

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    // RULE3 enable clears on reset
    always_ff @(posedge core_clk)
    begin
        if (reset)
            nmiEnable_reg <= RST_WORD;
        else if (wrNmiEn)
            nmiEnable_reg <= nmiEnable_next;
    end

    // RULE5 output port register
    always_ff @(posedge core_clk)
    begin
        if (reset)
            gpo_reg <= RST_WORD;
        else if (wrGpo)
            gpo_reg <= gpo_next;
    end

    // Sequencing idle before stop is left to software, so no interlock here
    always_ff @(posedge core_clk)
    begin
        if (reset)
            powerCtrl_reg <= RST_WORD;
        else if (wrPwrCtl)
            powerCtrl_reg <= powerCtrl_next;
    end

    // ------------------------------------------------------------
    // Warm reset handshake
    // ------------------------------------------------------------
    // RULE18 one-cycle request pulse
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            warmPulse_reg <= RST_WARM;
            warmDone_reg  <= RST_WARM;
        end
        else
        begin
            warmPulse_reg <= warmPulse_next;
            warmDone_reg  <= warmDone_next;
        end
    end

    // ------------------------------------------------------------
    // NMI causes
    // ------------------------------------------------------------
    nmi_cause_tracker u_nmi (
        .core_clk           (core_clk),
        .reset              (reset),
        .events             (nmiEvents),
        .external_nmi_pin_n (external_nmi_pin_n),
        .enables            (nmiEnable_reg[NMI_W-1:0]),
        .clearStatus        (clearNmi),
        .status             (nmiStatus),
        .nmiOut             (nmiRequest)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Registered so the value seen is the one before a read-clear
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdata_reg  <= RST_WORD;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= regReq.read;
            if (regReq.read)
                rdata_reg <= readWord;
        end
    end

    assign regRdata          = rdata_reg;
    assign regReadValid      = rvalid_reg;
    assign generalOutputPins = gpo_reg[GPO_W-1:0];
    assign warmResetPulse    = warmPulse_reg;
    assign clockGate         = powerCtrl_reg[PWR_STOP_LSB +: PWR_W];
    assign idleRequest       = powerCtrl_reg[PWR_IDLE_LSB +: PWR_W];

endmodule

`default_nettype wire

// *** tb/sysctl_asserts.sv ***
// Port-level checker for the system control register bank.
// Bound to the top module; sees only its ports, one clock domain.
`default_nettype none

module sysctl_asserts
    import sysctl_pkg::*;
#(
    parameter logic [7:0] REV_MAJOR = 8'h0A,
    parameter logic [7:0] REV_MINOR = 8'h0B
)
(
    input wire logic              core_clk,
    input wire logic              reset,
    input wire reg_req_t          regReq,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              regReadValid,
    input wire logic [GPO_W-1:0]  generalOutputPins,
    input wire logic [WARM_W-1:0] warmResetPulse,
    input wire logic [PWR_W-1:0]  clockGate,
    input wire logic [PWR_W-1:0]  idleRequest,
    input wire logic [PWR_W-1:0]  unitIdleAck,
    input wire logic [PWR_W-1:0]  unitWakeup
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Access decode and properties
    // ------------------------------------------------------------
    wire rdAt  = regReq.read;
    wire wrAt  = regReq.write;
    wire wrGpo = wrAt && regReq.addr == OFS_GPO && regReq.byteEn[0];
    wire wrRst = wrAt && regReq.addr == OFS_WARM_REQ && regReq.byteEn[0];
    wire wrPwc = wrAt && regReq.addr == OFS_POWER_CTRL;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_nmi_upper_zero: assert property (
        rdAt && regReq.addr == OFS_NMI_ENABLE |=> regRdata[31:6] == '0)
        else $error("nmi enable upper bits not zero");
    a_revision_fixed: assert property (
        rdAt && regReq.addr == OFS_REVISION
        |=> regReadValid && regRdata == {16'h0000, REV_MAJOR, REV_MINOR})
        else $error("revision read wrong");
    a_gpo_pins_follow: assert property (
        wrGpo |=> generalOutputPins == $past(regReq.wdata[7:0]))
        else $error("output pins did not follow write");
    a_gpo_pins_hold: assert property (
        !wrGpo |=> $stable(generalOutputPins))
        else $error("output pins moved without write");
    a_warm_pulse_out: assert property (
        wrRst |=> warmResetPulse == $past(regReq.wdata[4:0]))
        else $error("warm reset pulse mismatch");
    a_warm_no_write: assert property (
        !wrRst |=> warmResetPulse == '0)
        else $error("warm reset pulse without request");
    a_warm_reads_zero: assert property (
        rdAt && regReq.addr == OFS_WARM_REQ |=> regRdata == '0)
        else $error("warm request read not zero");
    a_power_status_map: assert property (
        rdAt && regReq.addr == OFS_POWER_STATUS
        |=> regRdata == {20'h0, $past(unitWakeup), 4'h0, $past(unitIdleAck)})
        else $error("power status layout wrong");
    a_clock_gate_write: assert property (
        wrPwc && regReq.byteEn[2] |=> clockGate == $past(regReq.wdata[19:16]))
        else $error("clock gate did not follow write");
    a_idle_req_write: assert property (
        wrPwc && regReq.byteEn[0] |=> idleRequest == $past(regReq.wdata[3:0]))
        else $error("idle request did not follow write");
endmodule

`default_nettype wire

// *** tb/unit_model.sv ***
// Far-side peripheral units: warm reset completion, idle ack, wakeup.
// Assumes the same core_clk; latency grows with unit index.
`default_nettype none

module unit_model
    import sysctl_pkg::*;
#(
    parameter int LAT = 4
)
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic [WARM_W-1:0] warmResetPulse,
    output logic      [WARM_W-1:0] unitResetDone,
    input  wire logic [PWR_W-1:0]  idleRequest,
    input  wire logic [PWR_W-1:0]  clockGate,
    input  wire logic [PWR_W-1:0]  wakeEvent,
    output logic      [PWR_W-1:0]  unitIdleAck,
    output logic      [PWR_W-1:0]  unitWakeup
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Unit behaviour
    // ------------------------------------------------------------
    int cnt [WARM_W];

    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < WARM_W; i++)
        begin
            unitResetDone[i] <= !reset && cnt[i] == 1;
            if (reset)
                cnt[i] <= 0;
            else if (warmResetPulse[i])
                cnt[i] <= LAT + i;
            else if (cnt[i] > 0)
                cnt[i] <= cnt[i] - 1;
        end
        unitIdleAck <= reset ? '0 : idleRequest;
        // Wakeup stays pending only while the clock is stopped
        unitWakeup <= reset ? '0 : (unitWakeup | wakeEvent) & clockGate;
    end
endmodule

`default_nettype wire

// *** tb/tb_system_ctrl_nmi_reset_power_regs.sv ***
// Self-checking bench for the system control register bank.
// Assumes the unit model on the far side and the checker bound below.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb_system_ctrl_nmi_reset_power_regs
    import sysctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 4;
    logic              core_clk = 1'b0;
    logic              reset = 1'b1;
    reg_req_t          regReq = '0;
    nmi_events_t       nmiEvents = '0;
    logic              external_nmi_pin_n = 1'b1;
    logic [PWR_W-1:0]  wakeEvent = '0;
    logic [DATA_W-1:0] regRdata;
    logic [DATA_W-1:0] d;
    logic              regReadValid;
    logic              nmiRequest;
    logic [GPO_W-1:0]  generalOutputPins;
    logic [WARM_W-1:0] warmResetPulse;
    logic [WARM_W-1:0] unitResetDone;
    logic [PWR_W-1:0]  clockGate;
    logic [PWR_W-1:0]  idleRequest;
    logic [PWR_W-1:0]  unitIdleAck;
    logic [PWR_W-1:0]  unitWakeup;
    int                fail_count = 0;
    int                check_count = 0;

    always #10 core_clk = ~core_clk;

    // Arbitrary identification values
    system_ctrl_nmi_reset_power_regs #(.REV_MAJOR(8'h3C), .REV_MINOR(8'h5A)) dut (
        .core_clk(core_clk), .reset(reset), .regReq(regReq), .regRdata(regRdata),
        .regReadValid(regReadValid), .nmiEvents(nmiEvents),
        .external_nmi_pin_n(external_nmi_pin_n), .nmiRequest(nmiRequest),
        .generalOutputPins(generalOutputPins), .warmResetPulse(warmResetPulse),
        .unitResetDone(unitResetDone), .clockGate(clockGate), .idleRequest(idleRequest),
        .unitIdleAck(unitIdleAck), .unitWakeup(unitWakeup));

    unit_model #(.LAT(LAT)) units (
        .core_clk(core_clk), .reset(reset), .warmResetPulse(warmResetPulse),
        .unitResetDone(unitResetDone), .idleRequest(idleRequest), .clockGate(clockGate),
        .wakeEvent(wakeEvent), .unitIdleAck(unitIdleAck), .unitWakeup(unitWakeup));

    // ------------------------------------------------------------
    // Access tasks and tests
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
        @(negedge core_clk);
        regReq = '{read: 1'b0, write: 1'b1, addr: a, byteEn: b, wdata: v};
        @(negedge core_clk);
        regReq = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] v);
        @(negedge core_clk);
        regReq = '{read: 1'b1, write: 1'b0, addr: a, byteEn: b, wdata: '0};
        @(negedge core_clk);
        regReq = '0;
        `CHK(regReadValid, 1'b1)
        v = regRdata;
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            rd(8'(i * 4), 4'hF, d);
            `CHK(d, (i == 2) ? 32'h0000_3C5A : 32'h0)
        end
        $display("Test reset_values done");
        for (int k = 0; k < NMI_W; k++)
        begin
            wr(OFS_NMI_ENABLE, 4'hF, ~(32'h1 << k));
            rd(OFS_NMI_ENABLE, 4'hF, d);
            `CHK(d, NMI_EN_MASK & ~(32'h1 << k))
            @(negedge core_clk);
            if (k == NMI_EXT_BIT)
                external_nmi_pin_n = 1'b0;
            else
                nmiEvents = nmi_events_t'(5'h1 << ((k == 5) ? 4 : k));
            @(negedge core_clk);
            external_nmi_pin_n = 1'b1;
            nmiEvents = '0;
            repeat (5) @(negedge core_clk);
            `CHK(nmiRequest, 1'b0)
            wr(OFS_NMI_ENABLE, 4'h1, 32'h1 << k);
            repeat (2) @(negedge core_clk);
            `CHK(nmiRequest, 1'b1)
            rd(OFS_NMI_STATUS, 4'h1, d);
            `CHK(d, 32'h1 << k)
            repeat (3) @(negedge core_clk);
            `CHK(nmiRequest, 1'b0)
        end
        // Event held across the clearing read: the flag must survive it
        nmiEvents.cpuBusError = 1'b1;
        rd(OFS_NMI_STATUS, 4'h1, d);
        `CHK(d, 32'h1)
        nmiEvents = '0;
        rd(OFS_NMI_STATUS, 4'h1, d);
        `CHK(d, 32'h1)
        rd(OFS_NMI_STATUS, 4'h1, d);
        `CHK(d, 32'h0)
        $display("Test nmi_causes done");
        wr(OFS_GPO, 4'hF, 32'hFFFF_FFA5);
        `CHK(generalOutputPins, 8'hA5)
        wr(OFS_GPO, 4'hE, 32'hFFFF_FF5A);
        rd(OFS_GPO, 4'hF, d);
        `CHK(d, 32'h0000_00A5)
        for (int n = 0; n < WARM_W; n++)
        begin
            wr(OFS_WARM_REQ, 4'h1, 32'h1 << n);
            `CHK(warmResetPulse, 5'(1 << n))
            rd(OFS_WARM_DONE, 4'hF, d);
            `CHK(d[n], 1'b0)
            repeat (LAT + 8) @(negedge core_clk);
            rd(OFS_WARM_DONE, 4'hF, d);
            `CHK(d, 32'((2 << n) - 1))
        end
        wr(OFS_WARM_REQ, 4'hF, 32'hFFFF_FFE0);
        `CHK(warmResetPulse, 5'h00)
        rd(OFS_WARM_REQ, 4'hF, d);
        `CHK(d, 32'h0)
        $display("Test port_and_warm_reset done");
        // Internal read drains posted writes first
        rd(OFS_POWER_STATUS, 4'hF, d);
        wr(OFS_POWER_CTRL, 4'h1, 32'h0000_000F);
        `CHK(idleRequest, 4'hF)
        rd(OFS_POWER_STATUS, 4'hF, d);
        `CHK(d, 32'h0000_000F)
        wr(OFS_POWER_CTRL, 4'hF, 32'hFFFF_FFFF);
        `CHK(clockGate, 4'hF)
        rd(OFS_POWER_CTRL, 4'hF, d);
        `CHK(d, PWR_CTL_MASK)
        wakeEvent = 4'h6;
        @(negedge core_clk);
        wakeEvent = '0;
        rd(OFS_POWER_STATUS, 4'hF, d);
        `CHK(d, 32'h0000_060F)
        wr(OFS_POWER_CTRL, 4'h4, 32'h0);
        `CHK(clockGate, 4'h0)
        rd(OFS_POWER_STATUS, 4'hF, d);
        `CHK(d, 32'h0000_000F)
        wr(OFS_POWER_CTRL, 4'h1, 32'h0);
        `CHK(idleRequest, 4'h0)
        $display("Test power_handshake done");
        report_and_stop();
    end

    // Whole run needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end
endmodule

bind system_ctrl_nmi_reset_power_regs sysctl_asserts #(
    .REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) chk (
    .core_clk(core_clk), .reset(reset), .regReq(regReq), .regRdata(regRdata),
    .regReadValid(regReadValid), .generalOutputPins(generalOutputPins),
    .warmResetPulse(warmResetPulse), .clockGate(clockGate), .idleRequest(idleRequest),
    .unitIdleAck(unitIdleAck), .unitWakeup(unitWakeup));

`default_nettype wire
